// ### shared/psd_pkg.sv
// constants, types and format decoding shared by the phase sequencer files
`default_nettype none
package psd_pkg;

    // phase pointer held in two bits, binary coded
    typedef enum logic [1:0] {
        PH_ZERO  = 2'h0,
        PH_ONE   = 2'h1,
        PH_TWO   = 2'h2,
        PH_THREE = 2'h3
    } psd_phase_t;

    typedef enum logic [1:0] {
        FMT_NONE = 2'h0,
        FMT_RR   = 2'h1,
        FMT_RX   = 2'h2,
        FMT_RS   = 2'h3
    } psd_fmt_t;

    // which phase-one routine the forced address selected
    typedef enum logic [1:0] {
        RT_NONE     = 2'h0,
        RT_RX_INDEX = 2'h1,
        RT_RX_PLAIN = 2'h2,
        RT_RS_INDEX = 2'h3
    } psd_routine_t;

    // forced microprogram entry addresses
    localparam logic [11:0] ADDR_NONE     = 12'h000;
    localparam logic [11:0] ADDR_RS_INDEX = 12'h004;
    localparam logic [11:0] ADDR_RX_PLAIN = 12'h008;
    localparam logic [11:0] ADDR_RX_INDEX = 12'h00C;
    localparam logic [11:0] ADDR_PHASE0   = 12'h010;
    localparam logic [11:0] ADDR_SERVICE  = 12'h014;
    localparam logic [11:0] ADDR_ILLEGAL  = 12'h200;
    // base of the generated dispatch routines, value arbitrary
    localparam logic [11:0] ADDR_DISP_BASE = 12'h400;

    // opcode high nibbles of each format
    localparam logic [3:0] NIB_RR_A = 4'h0;
    localparam logic [3:0] NIB_RR_B = 4'h2;
    localparam logic [3:0] NIB_RR_C = 4'h9;
    localparam logic [3:0] NIB_RX_A = 4'h4;
    localparam logic [3:0] NIB_RX_B = 4'h6;
    localparam logic [3:0] NIB_RX_C = 4'hD;
    localparam logic [3:0] NIB_RS_A = 4'hC;
    localparam logic [3:0] NIB_RS_B = 4'hE;

    // first-halfword fields; bit 0 of the instruction is bit 15 here
    localparam int FN_MSB = 15;
    localparam int FN_LSB = 8;
    localparam int R1_MSB = 7;
    localparam int R1_LSB = 4;
    localparam int X2_MSB = 3;
    localparam int X2_LSB = 0;

    localparam logic [15:0] LOC_STEP = 16'h0002;
    localparam logic [3:0] X2_NONE = 4'h0;
    localparam logic [15:0] REG16_RST = 16'h0000;
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam psd_phase_t PHASE_RST = PH_THREE;

    function automatic psd_fmt_t psd_classify(input logic [7:0] fnByte);
        logic [3:0] nib;
        nib = fnByte[7:4];
        if (nib == NIB_RR_A || nib == NIB_RR_B || nib == NIB_RR_C) begin
            psd_classify = FMT_RR;
        end else if (nib == NIB_RX_A || nib == NIB_RX_B || nib == NIB_RX_C) begin
            psd_classify = FMT_RX;
        end else if (nib == NIB_RS_A || nib == NIB_RS_B) begin
            psd_classify = FMT_RS;
        end else begin
            psd_classify = FMT_NONE;
        end
    endfunction

endpackage
`default_nettype wire

// ### rtl/psd_dispatch_table.sv
// opcode dispatch table: function byte to 12-bit routine start
`timescale 1ns/10ps
`default_nettype none
module psd_dispatch_table
    import psd_pkg::*;
(
    input wire logic [7:0] functionByte,
    output logic [11:0] routineAddr
);

    // undefined opcodes give an all-zero word
    always_comb begin
        if (psd_classify(functionByte) == FMT_NONE) begin
            routineAddr = ADDR_NONE;
        end else begin
            routineAddr = ADDR_DISP_BASE + {3'h0, functionByte, 1'b0};
        end
    end

endmodule // psd_dispatch_table
`default_nettype wire

// ### rtl/psd_phase_sequencer.sv
// four-phase user instruction sequencer with format decode and dispatch
`timescale 1ns/10ps
`default_nettype none
module psd_phase_sequencer
    import psd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic phaseDecode,
    input wire logic fetchLoad,
    input wire logic routineStep,
    input wire logic execValid,
    input wire logic [11:0] execAddr,
    input wire logic serviceDone,
    input wire logic ioInterrupt,
    input wire logic consoleAttention,
    input wire logic consoleSingle,
    input wire logic memParityFail,
    input wire logic powerFail,
    input wire logic memReadValid,
    input wire logic [15:0] memReadData,
    input wire logic [15:0] firstOperandGpr,
    input wire logic [15:0] indexGprRead,
    output logic [1:0] phase,
    output logic [11:0] microAddr,
    output logic microAddrLoad,
    output logic memReadReq,
    output logic [15:0] memReadAddr,
    output logic [15:0] instrPointer,
    output logic [15:0] instructionHoldReg,
    output logic [15:0] memoryDataReg,
    output logic [15:0] memoryAddressReg,
    output logic [15:0] accumulatorOperand,
    output logic [1:0] instrFormat,
    output logic indexEnable,
    output logic [3:0] firstRegField,
    output logic [3:0] indexField,
    output logic [15:0] immediateOperand,
    output logic illegalTrap
);

    psd_phase_t phase_ff, nxtPhase;
    psd_routine_t routine_ff, nxtRoutine;
    logic [11:0] microAddr_ff, nxtAddr;
    logic microAddrLoad_ff, nxtAddrLoad;
    logic memReadReq_ff, nxtReadReq;
    logic [15:0] memReadAddr_ff, nxtReadAddr;
    logic [15:0] instrPointer_ff;
    logic [15:0] instrHold_ff;
    logic [15:0] memDataReg_ff;
    logic [15:0] memAddrReg_ff;
    logic [15:0] accumOperand_ff;
    logic illegalTrap_ff;
    logic initGrace_ff;
    logic pointerStep;
    logic loadAccum;
    logic [11:0] dispatchWord;
    psd_fmt_t fmtNow;
    logic indexed;
    logic anyCondition;
    logic illegalHit;
    logic [7:0] functionByte;

    assign functionByte = instrHold_ff[FN_MSB:FN_LSB];
    assign fmtNow = psd_classify(functionByte);
    assign indexed = (instrHold_ff[X2_MSB:X2_LSB] != X2_NONE) && (fmtNow == FMT_RX || fmtNow == FMT_RS);
    assign anyCondition = ioInterrupt | consoleAttention | consoleSingle | memParityFail | powerFail;
    // zero location trap; the word left by reset is exempt once
    assign illegalHit = execValid && (execAddr == ADDR_NONE) && !initGrace_ff;

    psd_dispatch_table psd_dispatch_table_i (
        .functionByte(functionByte),
        .routineAddr(dispatchWord)
    );

    // phase change decode; illegal trap outranks a decode in the same cycle
    always_comb begin
        nxtPhase = phase_ff;
        nxtAddr = microAddr_ff;
        nxtAddrLoad = 1'b0;
        nxtReadReq = 1'b0;
        nxtReadAddr = memReadAddr_ff;
        nxtRoutine = routine_ff;
        pointerStep = 1'b0;
        loadAccum = 1'b0;
        if (illegalHit) begin
            nxtPhase = PH_THREE;
            nxtAddr = ADDR_ILLEGAL;
            nxtAddrLoad = 1'b1;
        end else if (phaseDecode) begin
            case (phase_ff)
                PH_ZERO: begin
                    if (fmtNow == FMT_RR) begin
                        loadAccum = 1'b1;
                        nxtPhase = PH_TWO;
                        nxtAddr = dispatchWord;
                        nxtAddrLoad = 1'b1;
                    end else begin
                        nxtReadReq = 1'b1;
                        nxtReadAddr = instrPointer_ff;
                        pointerStep = 1'b1;
                        nxtAddrLoad = 1'b1;
                        if (fmtNow == FMT_RX && indexed) begin
                            nxtPhase = PH_ONE;
                            nxtAddr = ADDR_RX_INDEX;
                            nxtRoutine = RT_RX_INDEX;
                        end else if (fmtNow == FMT_RX) begin
                            nxtPhase = PH_ONE;
                            nxtAddr = ADDR_RX_PLAIN;
                            nxtRoutine = RT_RX_PLAIN;
                        end else if (fmtNow == FMT_RS && indexed) begin
                            nxtPhase = PH_ONE;
                            nxtAddr = ADDR_RS_INDEX;
                            nxtRoutine = RT_RS_INDEX;
                        end else begin
                            nxtPhase = PH_TWO;
                            nxtAddr = dispatchWord;
                        end
                    end
                end
                PH_ONE: begin
                    // operand read only for memory format
                    nxtPhase = PH_TWO;
                    nxtAddr = dispatchWord;
                    nxtAddrLoad = 1'b1;
                    nxtRoutine = RT_NONE;
                    if (fmtNow == FMT_RX) begin
                        nxtReadReq = 1'b1;
                        nxtReadAddr = memAddrReg_ff;
                    end
                end
                PH_TWO: begin
                    nxtAddrLoad = 1'b1;
                    if (anyCondition) begin
                        nxtPhase = PH_THREE;
                        nxtAddr = ADDR_SERVICE;
                    end else begin
                        nxtPhase = PH_ZERO;
                        nxtAddr = ADDR_PHASE0;
                        nxtReadReq = 1'b1;
                        nxtReadAddr = instrPointer_ff;
                        pointerStep = 1'b1;
                    end
                end
                PH_THREE: begin
                    if (serviceDone) begin
                        nxtPhase = PH_ZERO;
                        nxtAddr = ADDR_PHASE0;
                        nxtAddrLoad = 1'b1;
                        nxtReadReq = 1'b1;
                        nxtReadAddr = instrPointer_ff;
                        pointerStep = 1'b1;
                    end
                end
                default: begin
                    nxtPhase = PH_THREE;
                end
            endcase
        end
    end

    // phase and address on one edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= PHASE_RST;
            microAddr_ff <= ADDR_RST;
            microAddrLoad_ff <= 1'b0;
            routine_ff <= RT_NONE;
        end else begin
            phase_ff <= nxtPhase;
            microAddr_ff <= nxtAddr;
            microAddrLoad_ff <= nxtAddrLoad;
            routine_ff <= nxtRoutine;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memReadReq_ff <= 1'b0;
            memReadAddr_ff <= REG16_RST;
        end else begin
            memReadReq_ff <= nxtReadReq;
            memReadAddr_ff <= nxtReadAddr;
        end
    end

    // pointer advances by two with each fetch read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instrPointer_ff <= REG16_RST;
        end else if (pointerStep) begin
            instrPointer_ff <= instrPointer_ff + LOC_STEP;
        end
    end

    // one illegal pulse; grace covers the zero word seen after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            illegalTrap_ff <= 1'b0;
            initGrace_ff <= 1'b1;
        end else begin
            illegalTrap_ff <= illegalHit;
            if (execValid) begin
                initGrace_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instrHold_ff <= REG16_RST;
        end else if (fetchLoad && phase_ff == PH_ZERO) begin
            instrHold_ff <= memDataReg_ff;
        end
    end

    // address may be modified by index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memAddrReg_ff <= REG16_RST;
        end else if (fetchLoad && phase_ff == PH_ZERO) begin
            memAddrReg_ff <= instrPointer_ff;
        end else if (routineStep && phase_ff == PH_ONE && routine_ff == RT_RX_INDEX) begin
            memAddrReg_ff <= memDataReg_ff + indexGprRead;
        end else if (routineStep && phase_ff == PH_ONE && routine_ff == RT_RX_PLAIN) begin
            memAddrReg_ff <= memDataReg_ff;
        end
    end

    // routine step wins over a late read return; reads are one at a time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memDataReg_ff <= REG16_RST;
        end else if (routineStep && phase_ff == PH_ONE && routine_ff == RT_RS_INDEX) begin
            memDataReg_ff <= memDataReg_ff + indexGprRead;
        end else if (memReadValid) begin
            memDataReg_ff <= memReadData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accumOperand_ff <= REG16_RST;
        end else if (loadAccum) begin
            accumOperand_ff <= firstOperandGpr;
        end
    end

    assign phase = phase_ff;
    assign microAddr = microAddr_ff;
    assign microAddrLoad = microAddrLoad_ff;
    assign memReadReq = memReadReq_ff;
    assign memReadAddr = memReadAddr_ff;
    assign instrPointer = instrPointer_ff;
    assign instructionHoldReg = instrHold_ff;
    assign memoryDataReg = memDataReg_ff;
    assign memoryAddressReg = memAddrReg_ff;
    assign accumulatorOperand = accumOperand_ff;
    assign illegalTrap = illegalTrap_ff;
    assign instrFormat = fmtNow;
    assign indexEnable = indexed;
    assign firstRegField = instrHold_ff[R1_MSB:R1_LSB];
    assign indexField = instrHold_ff[X2_MSB:X2_LSB];
    assign immediateOperand = memDataReg_ff;
    // checks
    sequence s_p0_decode;
        !illegalHit && phaseDecode && phase_ff == PH_ZERO;
    endsequence
    sequence s_p2_decode;
        !illegalHit && phaseDecode && phase_ff == PH_TWO;
    endsequence
    a_phase_hold_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (!phaseDecode && !illegalHit) |=> $stable(phase_ff))
        else $error("phase moved without decode");
    a_rx_index_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p0_decode and (fmtNow == FMT_RX && indexed))
        |=> phase_ff == PH_ONE && microAddr_ff == ADDR_RX_INDEX && microAddrLoad_ff && memReadReq_ff)
        else $error("indexed memory entry wrong");
    a_rx_plain_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p0_decode and (fmtNow == FMT_RX && !indexed))
        |=> phase_ff == PH_ONE && microAddr_ff == ADDR_RX_PLAIN)
        else $error("plain memory entry wrong");
    a_rs_index_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p0_decode and (fmtNow == FMT_RS && indexed))
        |=> phase_ff == PH_ONE && microAddr_ff == ADDR_RS_INDEX && instrPointer_ff == $past(instrPointer_ff) + LOC_STEP)
        else $error("indexed immediate entry wrong");
    a_rr_skip_one: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p0_decode and fmtNow == FMT_RR)
        |=> phase_ff == PH_TWO && $stable(instrPointer_ff) && !memReadReq_ff
            && accumOperand_ff == $past(firstOperandGpr))
        else $error("register format skip wrong");
    a_rs_skip_one: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p0_decode and (fmtNow == FMT_RS && !indexed))
        |=> phase_ff == PH_TWO && instrPointer_ff == $past(instrPointer_ff) + LOC_STEP)
        else $error("plain immediate skip wrong");
    a_dispatch_on_two: assert property (@(posedge clk) disable iff (!rst_n)
        (!illegalHit && phaseDecode && phase_ff != PH_TWO && nxtPhase == PH_TWO)
        |=> microAddr_ff == $past(dispatchWord) && microAddrLoad_ff)
        else $error("dispatch word not loaded");
    a_phase1_exit_read: assert property (@(posedge clk) disable iff (!rst_n)
        (!illegalHit && phaseDecode && phase_ff == PH_ONE)
        |=> phase_ff == PH_TWO && (memReadReq_ff == ($past(fmtNow) == FMT_RX)) && $stable(instrPointer_ff))
        else $error("phase one exit wrong");
    a_illegal_trap_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (execValid && execAddr == ADDR_NONE && !initGrace_ff)
        |=> phase_ff == PH_THREE && microAddr_ff == ADDR_ILLEGAL && illegalTrap_ff)
        else $error("illegal trap missed");
    a_service_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p2_decode and anyCondition)
        |=> phase_ff == PH_THREE && microAddr_ff == ADDR_SERVICE && $stable(instrPointer_ff) && !memReadReq_ff)
        else $error("service entry wrong");
    a_next_fetch: assert property (@(posedge clk) disable iff (!rst_n)
        (s_p2_decode and !anyCondition)
        |=> phase_ff == PH_ZERO && microAddr_ff == ADDR_PHASE0 && memReadReq_ff
            && memReadAddr_ff == $past(instrPointer_ff) && instrPointer_ff == $past(instrPointer_ff) + LOC_STEP)
        else $error("next fetch wrong");
    a_phase3_resume: assert property (@(posedge clk) disable iff (!rst_n)
        (!illegalHit && phaseDecode && phase_ff == PH_THREE)
        |=> (phase_ff == PH_ZERO) == $past(serviceDone) && ($past(serviceDone) || phase_ff == PH_THREE))
        else $error("phase three exit wrong");
endmodule // psd_phase_sequencer
`default_nettype wire

// ### tb/psd_mem_model.sv
// behavioural core memory answering one halfword read at a time
`timescale 1ns/10ps
`default_nettype none
module psd_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic memReadReq,
    input wire logic [15:0] memReadAddr,
    output logic memReadValid,
    output logic [15:0] memReadData
);
    logic [15:0] mem [0:127];
    logic [15:0] addrHold;
    int waitCnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memReadValid <= 1'b0;
            memReadData <= 16'hFFFF;
            addrHold <= 16'h0000;
            waitCnt <= 0;
        end else begin
            memReadValid <= 1'b0;
            // data toggles outside valid so a stale value never looks right
            memReadData <= ~memReadData;
            if (memReadReq) begin
                addrHold <= memReadAddr;
                waitCnt <= slow ? 4 : 1;
            end else if (waitCnt > 1) begin
                waitCnt <= waitCnt - 1;
            end else if (waitCnt == 1) begin
                waitCnt <= 0;
                memReadValid <= 1'b1;
                memReadData <= mem[addrHold[7:1]];
            end
        end
    end
endmodule // psd_mem_model
`default_nettype wire

// ### tb/psd_phase_sequencer_bench.sv
// self-checking bench for the phase sequencer
`timescale 1ns/10ps
`default_nettype none
module psd_phase_sequencer_bench
    import psd_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, phaseDecode = 1'b0, fetchLoad = 1'b0, routineStep = 1'b0;
    logic execValid = 1'b0, serviceDone = 1'b0, slow = 1'b0, memReadValid, microAddrLoad, memReadReq;
    logic indexEnable, illegalTrap;
    logic [11:0] execAddr = 12'h000, microAddr;
    logic [4:0] cond = 5'h00;
    logic [15:0] memReadData, memReadAddr, instrPointer, instructionHoldReg, memoryDataReg;
    logic [15:0] memoryAddressReg, accumulatorOperand, immediateOperand, expPtr = 16'h0000;
    logic [1:0] phase, instrFormat;
    logic [3:0] firstRegField, indexField;
    // five condition rounds each fetch one more halfword, so the tail runs to word 15
    logic [15:0] prog [0:15] = '{16'h4312, 16'h1000, 16'h6D10, 16'h2000, 16'hC123, 16'h0100, 16'hE120,
        16'h0055, 16'h2345, 16'h1000, 16'h2345, 16'h2345, 16'h2345, 16'h2345, 16'h2345, 16'h2345};
    int mismatches = 0, checks = 0;
    always #25 clk = ~clk;
    psd_phase_sequencer psd_phase_sequencer_i (.clk(clk), .rst_n(rst_n), .phaseDecode(phaseDecode),
        .fetchLoad(fetchLoad), .routineStep(routineStep), .execValid(execValid), .execAddr(execAddr),
        .serviceDone(serviceDone), .ioInterrupt(cond[0]), .consoleAttention(cond[1]),
        .consoleSingle(cond[2]), .memParityFail(cond[3]), .powerFail(cond[4]),
        .memReadValid(memReadValid), .memReadData(memReadData), .firstOperandGpr(16'h0777),
        .indexGprRead(16'h0030), .phase(phase), .microAddr(microAddr), .microAddrLoad(microAddrLoad),
        .memReadReq(memReadReq), .memReadAddr(memReadAddr), .instrPointer(instrPointer),
        .instructionHoldReg(instructionHoldReg), .memoryDataReg(memoryDataReg),
        .memoryAddressReg(memoryAddressReg), .accumulatorOperand(accumulatorOperand),
        .instrFormat(instrFormat), .indexEnable(indexEnable), .firstRegField(firstRegField),
        .indexField(indexField), .immediateOperand(immediateOperand), .illegalTrap(illegalTrap));
    psd_mem_model psd_mem_model_i (.clk(clk), .rst_n(rst_n), .slow(slow), .memReadReq(memReadReq),
        .memReadAddr(memReadAddr), .memReadValid(memReadValid), .memReadData(memReadData));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #5;
    endtask
    task automatic decode();
        phaseDecode = 1'b1;
        tick();
        phaseDecode = 1'b0;
    endtask
    function automatic logic [11:0] disp(input logic [7:0] fn);
        return ADDR_DISP_BASE + {3'h0, fn, 1'b0};
    endfunction
    task automatic step(input logic [1:0] ph, input logic [11:0] ma, input logic rq);
        check("phase", 16'(phase), 16'(ph));
        check("microAddr", 16'(microAddr), 16'(ma));
        check("memReadReq", 16'(memReadReq), 16'(rq));
    endtask
    // bounded wait, then one edge for the data register to load
    task automatic wait_data();
        for (int i = 0; i < 20 && memReadValid !== 1'b1; i++) tick();
        check("read return", 16'(memReadValid), 16'h0001);
        tick();
    endtask
    task automatic fetch(input logic [15:0] hw, input logic [1:0] fmt);
        wait_data();
        fetchLoad = 1'b1;
        tick();
        fetchLoad = 1'b0;
        check("hold reg", instructionHoldReg, hw);
        check("address reg", memoryAddressReg, expPtr);
        check("format", 16'(instrFormat), 16'(fmt));
        check("phase kept", 16'(phase), 16'h0000);
    endtask
    task automatic read_step(input logic [1:0] ph, input logic [11:0] ma);
        step(ph, ma, 1'b1);
        check("read addr", memReadAddr, expPtr);
        expPtr = expPtr + LOC_STEP;
        check("pointer", instrPointer, expPtr);
    endtask
    task automatic exit2();
        tick();
        decode();
        read_step(PH_ZERO, ADDR_PHASE0);
    endtask
    task automatic resume();
        serviceDone = 1'b1;
        decode();
        serviceDone = 1'b0;
        read_step(PH_ZERO, ADDR_PHASE0);
    endtask
    task automatic enter1(input logic [11:0] ma);
        decode();
        read_step(PH_ONE, ma);
        wait_data();
        routineStep = 1'b1;
        tick();
        routineStep = 1'b0;
    endtask
    task automatic t_reset();
        step(PH_THREE, ADDR_NONE, 1'b0);
        check("pointer reset", instrPointer, 16'h0000);
        execValid = 1'b1;
        tick();
        execValid = 1'b0;
        check("grace trap", 16'(illegalTrap), 16'h0000);
        decode();
        step(PH_THREE, ADDR_NONE, 1'b0);
        check("load pulse", 16'(microAddrLoad), 16'h0000);
        tick();
        resume();
        check("load pulse", 16'(microAddrLoad), 16'h0001);
    endtask
    task automatic t_rx_index();
        fetch(16'h4312, FMT_RX);
        check("index enable", 16'(indexEnable), 16'h0001);
        check("index field", 16'(indexField), 16'h0002);
        check("first reg", 16'(firstRegField), 16'h0001);
        enter1(ADDR_RX_INDEX);
        check("eff addr", memoryAddressReg, 16'h1030);
        tick();
        decode();
        step(PH_TWO, disp(8'h43), 1'b1);
        check("operand addr", memReadAddr, 16'h1030);
        slow = 1'b1;
        wait_data();
        slow = 1'b0;
        exit2();
    endtask
    task automatic t_rx_plain();
        fetch(16'h6D10, FMT_RX);
        check("index enable", 16'(indexEnable), 16'h0000);
        enter1(ADDR_RX_PLAIN);
        check("plain addr", memoryAddressReg, 16'h2000);
        tick();
        decode();
        step(PH_TWO, disp(8'h6D), 1'b1);
        wait_data();
        exit2();
    endtask
    task automatic t_rs_index();
        fetch(16'hC123, FMT_RS);
        enter1(ADDR_RS_INDEX);
        check("eff data", memoryDataReg, 16'h0130);
        tick();
        decode();
        step(PH_TWO, disp(8'hC1), 1'b0);
        exit2();
    endtask
    task automatic t_rs_plain();
        fetch(16'hE120, FMT_RS);
        check("index enable", 16'(indexEnable), 16'h0000);
        decode();
        read_step(PH_TWO, disp(8'hE1));
        wait_data();
        check("immediate", immediateOperand, 16'h0055);
        exit2();
    endtask
    task automatic t_rr();
        fetch(16'h2345, FMT_RR);
        decode();
        step(PH_TWO, disp(8'h23), 1'b0);
        check("pointer held", instrPointer, expPtr);
        check("accumulator", accumulatorOperand, 16'h0777);
        execAddr = disp(8'h23);
        execValid = 1'b1;
        tick();
        execValid = 1'b0;
        check("phase kept", 16'(phase), 16'h0002);
        exit2();
    endtask
    task automatic t_illegal();
        fetch(16'h1000, FMT_NONE);
        decode();
        read_step(PH_TWO, ADDR_NONE);
        wait_data();
        execAddr = ADDR_NONE;
        execValid = 1'b1;
        tick();
        execValid = 1'b0;
        step(PH_THREE, ADDR_ILLEGAL, 1'b0);
        check("trap", 16'(illegalTrap), 16'h0001);
        tick();
        resume();
    endtask
    task automatic t_conditions();
        for (int i = 0; i < 5; i++) begin
            fetch(16'h2345, FMT_RR);
            decode();
            tick();
            cond = 5'(5'h01 << i);
            decode();
            cond = 5'h00;
            step(PH_THREE, ADDR_SERVICE, 1'b0);
            check("pointer held", instrPointer, expPtr);
            tick();
            resume();
        end
    endtask
    initial begin
        for (int k = 0; k < 128; k++) psd_mem_model_i.mem[k] = (k < 16) ? prog[k] : 16'h0000;
        repeat (16) @(posedge clk);
        #5;
        rst_n = 1'b1;
        t_reset();
        t_rx_index();
        t_rx_plain();
        t_rs_index();
        t_rs_plain();
        t_rr();
        t_illegal();
        t_conditions();
        stop_test();
    end
    // whole run is under 150 cycles
    initial begin
        #(50 * 5000);
        mismatches++;
        stop_test();
    end
endmodule // psd_phase_sequencer_bench
`default_nettype wire
